/* verilog/timed_io_pkg.sv */
`default_nettype none
package timed_io_pkg;
  localparam int WORD_W = 32;
  localparam int CNT_W = 16;
  localparam int DIV_W = 8;
  localparam int NUM_BLOCKS = 6;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] RESET_BLOCK = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam int REF_CLOCK_MHZ = 100;
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} cond_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} xfer_state_t;
endpackage : timed_io_pkg
`default_nettype wire

/* verilog/clock_block.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_block
  import timed_io_pkg::*;
#(
  parameter bit FIXED_REF = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic use_external,
  input wire logic ext_level,
  input wire logic div_load,
  input wire logic [DIV_W-1:0] div_value,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] ratio;
    logic [DIV_W-1:0] cnt;
    logic ext_prev;
    logic ext_sel;
  } cb_state_t;

  cb_state_t s_ff;
  cb_state_t nxt_s;
  logic src_edge;
  logic [DIV_W-1:0] ratio_eff;

  // The reference block ticks every cycle; others count source edges.
  assign src_edge = (FIXED_REF || !s_ff.ext_sel) ? 1'b1 : (ext_level && !s_ff.ext_prev);
  assign ratio_eff = (s_ff.ratio == 8'h00) ? DIV_RESET : s_ff.ratio;
  assign tick = src_edge && (s_ff.cnt == ratio_eff - DIV_RESET);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ext_prev = ext_level;
    nxt_s.ext_sel = FIXED_REF ? 1'b0 : use_external;
    if (src_edge) begin
      nxt_s.cnt = tick ? 8'h00 : s_ff.cnt + 8'h01;
    end
    if (div_load && !FIXED_REF) begin
      nxt_s.ratio = div_value;
      nxt_s.cnt = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_ff <= '{ratio: DIV_RESET, cnt: 8'h00, ext_prev: 1'b0, ext_sel: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  property p_div_reset;
    @(posedge clock) disable iff (!reset_n) $rose(reset_n) |-> s_ff.ratio == DIV_RESET;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("Divider ratio not one after reset.");

  property p_ext_divide;
    @(posedge clock) disable iff (!reset_n)
      (tick && s_ff.ext_sel && ratio_eff == 8'h02 && !div_load) |=> !tick;
  endproperty
  a_ext_divide: assert property (p_ext_divide) else $error("Divided clock ticked too soon.");
endmodule : clock_block
`default_nettype wire

/* verilog/timed_io_port_unit.sv */
// How it works
// - Port width is 1, 4, 8, 16 or 32.
// - All pins share one direction.
// - Drive pins or sample with optional condition.
// - Each processor access completes in one cycle.
// - Open drain: drive low, release high.
// - Serialiser plus transfer register buffer data.
// - 16-bit counter times pin transfers.
// - Counter value readable at any time.
// - Each transfer captures counter as timestamp.
// - Enabled link disconnects the port pins.
// - Narrower enabled port owns shared pins.
// - Unshared pins stay with wider port.
// - Port always transfers at its width.
// - Six clock blocks, block 0 reference.
// - Clock block may use 1-bit port.
// - External clock may be divided.
// - Input port honours external input strobe.
// - Output port can generate output strobe.
// - After reset ports use clock block 0.
// - Pin events go to the scheduler.
// - Pull-downs enabled while held in reset.
`timescale 1ns/100ps
`default_nettype none
module timed_io_port_unit
  import timed_io_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_enable,
  input wire logic cfg_is_output,
  input wire logic cfg_open_drain,
  input wire logic cfg_strobe_in_en,
  input wire logic cfg_strobe_out_en,
  input wire cond_mode_t cfg_cond_mode,
  input wire logic [WIDTH-1:0] cfg_cond_value,
  input wire logic cfg_clock_load,
  input wire logic [SEL_W-1:0] cfg_clock_sel,
  input wire logic [NUM_BLOCKS-1:0] cfg_block_external,
  input wire logic [NUM_BLOCKS-1:0] cfg_block_div_load,
  input wire logic [DIV_W-1:0] cfg_block_div_value,
  input wire logic ext_clock_pin,
  input wire logic link_enable,
  input wire logic [WIDTH-1:0] narrower_owns,
  input wire logic cpu_write,
  input wire logic [WORD_W-1:0] cpu_write_data,
  output logic cpu_write_ready,
  input wire logic cpu_read,
  output logic cpu_read_ready,
  output logic cpu_read_valid,
  output logic [WORD_W-1:0] cpu_read_data,
  output logic [CNT_W-1:0] cpu_read_stamp,
  input wire logic cpu_time_arm,
  input wire logic [CNT_W-1:0] cpu_time_value,
  input wire logic cpu_cond_arm,
  output logic [CNT_W-1:0] counter_value,
  output logic [CNT_W-1:0] last_stamp,
  output logic pin_event,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic pin_pulldown,
  input wire logic input_strobe,
  output logic output_strobe
);
  localparam int STEPS = WORD_W / WIDTH;
  localparam logic [5:0] LAST_STEPS = 6'(STEPS - 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [WORD_W-1:0] xfer;
    logic xfer_full;
    logic [WORD_W-1:0] shift;
    logic [5:0] steps;
    logic [CNT_W-1:0] stamp;
    logic time_armed;
    logic [CNT_W-1:0] time_val;
    logic cond_pending;
    logic [WIDTH-1:0] drive;
    logic strobe;
    logic event_p;
    logic [WORD_W-1:0] rd_data;
    logic [CNT_W-1:0] rd_stamp;
    logic rd_valid;
    logic [SEL_W-1:0] clk_sel;
    xfer_state_t st;
  } port_state_t;

  port_state_t s_ff;
  port_state_t nxt_s;
  logic [NUM_BLOCKS-1:0] block_tick;
  logic tick;
  logic [WIDTH-1:0] pin_conn;
  logic [WIDTH-1:0] pins_seen;
  logic time_ok;
  logic cond_ok;
  logic strobe_ok;

  function automatic logic [WORD_W-1:0] shift_down(input logic [WORD_W-1:0] w);
    shift_down = w >> WIDTH;
  endfunction : shift_down

  function automatic logic cond_match(input cond_mode_t m, input logic [WIDTH-1:0] v,
                                      input logic [WIDTH-1:0] p);
    case (m)
      COND_EQ: cond_match = (p == v);
      COND_NE: cond_match = (p != v);
      default: cond_match = 1'b1;
    endcase
  endfunction : cond_match

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_block
      clock_block #(.FIXED_REF(gi == 0)) u_block (
        .clock(clock),
        .reset_n(reset_n),
        .use_external(cfg_block_external[gi]),
        .ext_level(ext_clock_pin),
        .div_load(cfg_block_div_load[gi]),
        .div_value(cfg_block_div_value),
        .tick(block_tick[gi])
      );
    end
  endgenerate

  assign tick = (s_ff.clk_sel < SEL_W'(NUM_BLOCKS)) ? block_tick[s_ff.clk_sel] : 1'b0;

  // Links take every pin; a narrower enabled port takes only the shared ones.
  assign pin_conn = (cfg_enable && !link_enable) ? ~narrower_owns : '0;
  assign pins_seen = pin_in & pin_conn;

  assign time_ok = !s_ff.time_armed || (s_ff.count == s_ff.time_val);
  assign cond_ok = !s_ff.cond_pending || cond_match(cfg_cond_mode, cfg_cond_value, pins_seen);
  assign strobe_ok = !cfg_strobe_in_en || input_strobe;

  assign cpu_write_ready = cfg_is_output && !s_ff.xfer_full;
  assign cpu_read_ready = !cfg_is_output && s_ff.xfer_full;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.event_p = 1'b0;
    nxt_s.rd_valid = 1'b0;
    if (cfg_clock_load) begin
      nxt_s.clk_sel = cfg_clock_sel;
    end
    if (cpu_time_arm) begin
      nxt_s.time_armed = 1'b1;
      nxt_s.time_val = cpu_time_value;
    end
    if (cpu_cond_arm) begin
      nxt_s.cond_pending = 1'b1;
    end
    if (cpu_read && cpu_read_ready) begin
      nxt_s.rd_data = s_ff.xfer;
      nxt_s.rd_stamp = s_ff.stamp;
      nxt_s.rd_valid = 1'b1;
      nxt_s.xfer_full = 1'b0;
    end
    if (cpu_write && cpu_write_ready) begin
      nxt_s.xfer = cpu_write_data;
      nxt_s.xfer_full = 1'b1;
    end
    if (tick) begin
      nxt_s.count = s_ff.count + 16'h0001;
      if (cfg_is_output) begin
        case (s_ff.st)
          ST_IDLE: begin
            if (s_ff.xfer_full && time_ok) begin
              nxt_s.drive = s_ff.xfer[WIDTH-1:0];
              nxt_s.shift = shift_down(s_ff.xfer);
              nxt_s.steps = LAST_STEPS;
              nxt_s.stamp = s_ff.count;
              nxt_s.time_armed = 1'b0;
              nxt_s.xfer_full = 1'b0;
              nxt_s.strobe = 1'b1;
              nxt_s.st = (STEPS > 1) ? ST_SHIFT : ST_IDLE;
            end else begin
              nxt_s.strobe = 1'b0;
            end
          end
          ST_SHIFT: begin
            nxt_s.drive = s_ff.shift[WIDTH-1:0];
            nxt_s.shift = shift_down(s_ff.shift);
            nxt_s.steps = s_ff.steps - 6'h01;
            nxt_s.strobe = 1'b1;
            if (s_ff.steps == 6'h01) begin
              nxt_s.st = ST_IDLE;
            end
          end
          default: nxt_s.st = ST_IDLE;
        endcase
      end else begin
        nxt_s.strobe = 1'b0;
        case (s_ff.st)
          ST_IDLE: begin
            if (time_ok && cond_ok && strobe_ok) begin
              nxt_s.shift = shift_down(s_ff.shift) | (WORD_W'(pins_seen) << (WORD_W - WIDTH));
              nxt_s.steps = LAST_STEPS;
              nxt_s.time_armed = 1'b0;
              if (s_ff.cond_pending) begin
                nxt_s.cond_pending = 1'b0;
                nxt_s.event_p = 1'b1;
              end
              if (STEPS == 1) begin
                if (!s_ff.xfer_full) begin
                  nxt_s.xfer = WORD_W'(pins_seen);
                  nxt_s.stamp = s_ff.count;
                  nxt_s.xfer_full = 1'b1;
                end
              end else begin
                nxt_s.st = ST_SHIFT;
              end
            end
          end
          ST_SHIFT: begin
            if (strobe_ok) begin
              nxt_s.shift = shift_down(s_ff.shift) | (WORD_W'(pins_seen) << (WORD_W - WIDTH));
              nxt_s.steps = s_ff.steps - 6'h01;
              if (s_ff.steps == 6'h01) begin
                nxt_s.st = ST_IDLE;
                // A full transfer register keeps its word; the new one is dropped.
                if (!s_ff.xfer_full) begin
                  nxt_s.xfer = nxt_s.shift;
                  nxt_s.stamp = s_ff.count;
                  nxt_s.xfer_full = 1'b1;
                end
              end
            end
          end
          default: nxt_s.st = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.count <= COUNT_RESET;
      s_ff.clk_sel <= RESET_BLOCK;
      s_ff.st <= ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign counter_value = s_ff.count;
  assign last_stamp = s_ff.stamp;
  assign cpu_read_valid = s_ff.rd_valid;
  assign cpu_read_data = s_ff.rd_data;
  assign cpu_read_stamp = s_ff.rd_stamp;
  assign pin_event = s_ff.event_p;
  assign output_strobe = cfg_is_output && cfg_strobe_out_en && s_ff.strobe;
  assign pin_pulldown = !reset_n;
  // Inputs never drive; open drain only enables the driver for a zero.
  assign pin_out = cfg_open_drain ? '0 : s_ff.drive;
  assign pin_oe = !cfg_is_output ? '0 :
                  (cfg_open_drain ? (~s_ff.drive & pin_conn) : pin_conn);

  property p_count_step;
    @(posedge clock) disable iff (!reset_n) tick |=> counter_value == $past(counter_value) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("Counter did not step on tick.");

  property p_count_hold;
    @(posedge clock) disable iff (!reset_n) !tick |=> $stable(counter_value);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("Counter moved without tick.");

  property p_read_once;
    @(posedge clock) disable iff (!reset_n)
      (cpu_read && cpu_read_ready) |=> cpu_read_valid && cpu_read_data == $past(s_ff.xfer);
  endproperty
  a_read_once: assert property (p_read_once) else $error("Read not answered next cycle.");

  property p_write_once;
    @(posedge clock) disable iff (!reset_n) (cpu_write && cpu_write_ready) |=> s_ff.xfer_full;
  endproperty
  a_write_once: assert property (p_write_once) else $error("Write not taken in one cycle.");

  property p_open_drain;
    @(posedge clock) disable iff (!reset_n) cfg_open_drain |-> (pin_out == '0) && ((pin_oe & s_ff.drive) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open drain drove a one.");

  property p_pin_owner;
    @(posedge clock) disable iff (!reset_n) (pin_oe & narrower_owns) == '0 && (!link_enable || pin_oe == '0);
  endproperty
  a_pin_owner: assert property (p_pin_owner) else $error("Pin driven while owned elsewhere.");

  property p_one_dir;
    @(posedge clock) disable iff (!reset_n) !cfg_is_output |-> pin_oe == '0 && !output_strobe;
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("Input port drove its pins.");

  sequence s_timed_launch;
    tick && cfg_is_output && s_ff.st == ST_IDLE && s_ff.xfer_full && s_ff.time_armed &&
    s_ff.count == s_ff.time_val;
  endsequence

  property p_timed_launch;
    @(posedge clock) disable iff (!reset_n)
      s_timed_launch |=> last_stamp == $past(counter_value) && s_ff.drive == $past(s_ff.xfer[WIDTH-1:0]);
  endproperty
  a_timed_launch: assert property (p_timed_launch) else $error("Timed output missed its count.");

  property p_no_early;
    @(posedge clock) disable iff (!reset_n)
      (tick && s_ff.time_armed && s_ff.count != s_ff.time_val && s_ff.st == ST_IDLE) |=> $stable(last_stamp);
  endproperty
  a_no_early: assert property (p_no_early) else $error("Transfer before programmed time.");

  property p_reset_block;
    @(posedge clock) disable iff (!reset_n) $rose(reset_n) |-> s_ff.clk_sel == RESET_BLOCK;
  endproperty
  a_reset_block: assert property (p_reset_block) else $error("Port not on block 0 after reset.");

  sequence s_cond_hit;
    tick && !cfg_is_output && s_ff.st == ST_IDLE && s_ff.cond_pending && time_ok && cond_ok && strobe_ok;
  endsequence

  property p_event;
    @(posedge clock) disable iff (!reset_n) s_cond_hit |=> pin_event ##1 !pin_event;
  endproperty
  a_event: assert property (p_event) else $error("Condition met without one event pulse.");
endmodule : timed_io_port_unit
`default_nettype wire

/* tb/pin_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_partner #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic start,
  input wire logic slow,
  input wire logic [31:0] word,
  output logic [WIDTH-1:0] pin_in,
  output logic input_strobe
);
  logic [31:0] shift;
  logic gap;
  logic go;
  int left;
  initial begin
    pin_in = '0;
    input_strobe = 1'b0;
    shift = '0;
    gap = 1'b0;
    left = 0;
  end
  // Outside a strobed beat the data lines flip every cycle, so stale data never looks valid.
  always @(posedge clock) begin
    go = start;
    #1;
    if (go) begin
      shift = word;
      left = 32 / WIDTH;
      gap = 1'b0;
    end
    if (left > 0 && !(slow && gap)) begin
      pin_in = shift[WIDTH-1:0];
      input_strobe = 1'b1;
      shift = shift >> WIDTH;
      left--;
    end else begin
      pin_in = ~pin_in;
      input_strobe = 1'b0;
    end
    gap = ~gap;
  end
endmodule : pin_partner
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import timed_io_pkg::*;
  localparam int W = 8;
  logic clock = 1'b0;
  logic reset_n, cfg_enable, cfg_is_output, cfg_open_drain, cfg_strobe_in_en, cfg_strobe_out_en;
  cond_mode_t cfg_cond_mode;
  logic [W-1:0] cfg_cond_value, narrower_owns, pin_in, pin_out, pin_oe;
  logic cfg_clock_load, ext_clock_pin, link_enable, cpu_write, cpu_read, cpu_time_arm, cpu_cond_arm;
  logic [SEL_W-1:0] cfg_clock_sel;
  logic [NUM_BLOCKS-1:0] cfg_block_external, cfg_block_div_load;
  logic [DIV_W-1:0] cfg_block_div_value;
  logic [WORD_W-1:0] cpu_write_data, cpu_read_data;
  logic [CNT_W-1:0] cpu_time_value, counter_value, last_stamp, cpu_read_stamp, c0, tv;
  logic cpu_write_ready, cpu_read_ready, cpu_read_valid, pin_event, pin_pulldown;
  logic input_strobe, output_strobe, p_start, p_slow;
  logic [31:0] p_word, rng, w;
  int mismatches = 0, n_checks = 0, events = 0, e0;

  timed_io_port_unit #(.WIDTH(W)) timed_io_port_unit_inst (.clock(clock), .reset_n(reset_n),
    .cfg_enable(cfg_enable), .cfg_is_output(cfg_is_output), .cfg_open_drain(cfg_open_drain),
    .cfg_strobe_in_en(cfg_strobe_in_en), .cfg_strobe_out_en(cfg_strobe_out_en),
    .cfg_cond_mode(cfg_cond_mode), .cfg_cond_value(cfg_cond_value),
    .cfg_clock_load(cfg_clock_load), .cfg_clock_sel(cfg_clock_sel),
    .cfg_block_external(cfg_block_external), .cfg_block_div_load(cfg_block_div_load),
    .cfg_block_div_value(cfg_block_div_value), .ext_clock_pin(ext_clock_pin),
    .link_enable(link_enable), .narrower_owns(narrower_owns), .cpu_write(cpu_write),
    .cpu_write_data(cpu_write_data), .cpu_write_ready(cpu_write_ready), .cpu_read(cpu_read),
    .cpu_read_ready(cpu_read_ready), .cpu_read_valid(cpu_read_valid),
    .cpu_read_data(cpu_read_data), .cpu_read_stamp(cpu_read_stamp),
    .cpu_time_arm(cpu_time_arm), .cpu_time_value(cpu_time_value), .cpu_cond_arm(cpu_cond_arm),
    .counter_value(counter_value), .last_stamp(last_stamp), .pin_event(pin_event),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pulldown),
    .input_strobe(input_strobe), .output_strobe(output_strobe));
  pin_partner #(.WIDTH(W)) pin_partner_inst (.clock(clock), .start(p_start), .slow(p_slow),
    .word(p_word), .pin_in(pin_in), .input_strobe(input_strobe));

  always #4 clock = ~clock;
  always @(posedge clock) if (pin_event === 1'b1) events++;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  function automatic void rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
  endfunction : rnd

  function automatic logic [W-1:0] exp_oe(input logic [W-1:0] b, input logic od,
                                          input logic [W-1:0] own, input logic lk);
    return lk ? '0 : (~own & (od ? ~b : '1));
  endfunction : exp_oe

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic wait_hi(input int s);
    logic hit;
    for (int i = 0; i < 300; i++) begin
      hit = s == 0 ? cpu_write_ready : s == 1 ? output_strobe : s == 2 ? cpu_read_ready :
            cpu_read_valid;
      if (hit === 1'b1) return;
      tick();
    end
    mismatches++;
    $display("[FAIL] %0t wait %0d timed out", $time, s);
    stop_test();
  endtask : wait_hi

  task automatic send(input logic [31:0] d, input logic od, input logic [W-1:0] own,
                      input logic lk, input logic arm);
    cfg_is_output = 1'b1;
    cfg_open_drain = od;
    narrower_owns = own;
    link_enable = lk;
    tv = counter_value + 16'h0028;
    cpu_time_value = tv;
    cpu_time_arm = arm;
    tick();
    cpu_time_arm = 1'b0;
    wait_hi(0);
    cpu_write = 1'b1;
    cpu_write_data = d;
    tick();
    cpu_write = 1'b0;
    wait_hi(1);
    if (arm) check(last_stamp, tv, "timed stamp");
    for (int i = 0; i < 32 / W; i++) begin
      check(pin_oe, exp_oe(d[i*W+:W], od, own, lk), "enable");
      if (od) check(pin_out & pin_oe, '0, "open drain");
      else if (!lk) check(pin_out & ~own, d[i*W+:W] & ~own, "pins");
      check(output_strobe, 1'b1, "strobe");
      tick();
    end
    check(output_strobe, 1'b0, "strobe end");
    $display("output word %h done", d);
  endtask : send

  task automatic recv(input logic [31:0] d, input logic slow);
    cfg_is_output = 1'b0;
    p_word = d;
    p_slow = slow;
    p_start = 1'b1;
    tick();
    p_start = 1'b0;
    wait_hi(2);
    // Block 0 ticks every cycle, so the last sample was taken one count ago.
    tv = counter_value - 16'h0001;
    check(last_stamp, tv, "input stamp");
    cpu_read = 1'b1;
    tick();
    cpu_read = 1'b0;
    wait_hi(3);
    check(cpu_read_data, d, "read word");
    check(cpu_read_stamp, tv, "read stamp");
    $display("input word %h done", d);
  endtask : recv

  task automatic clk_test(input logic [SEL_W-1:0] b, input int n, input int exp, input bit ext);
    cfg_clock_sel = b;
    cfg_clock_load = 1'b1;
    tick();
    cfg_clock_load = 1'b0;
    for (int i = 0; i < n + 8; i++) begin
      if (ext) ext_clock_pin = (i % 4) < 2;
      if (i == 8) c0 = counter_value;
      tick();
    end
    check(counter_value - c0, exp[CNT_W-1:0], "tick count");
    $display("clock block %0d done", b);
  endtask : clk_test

  initial begin
    rng = 32'h49EA;
    reset_n = 1'b0;
    {cfg_is_output, cfg_open_drain, cfg_clock_load, ext_clock_pin, link_enable} = '0;
    {cpu_write, cpu_read, cpu_time_arm, cpu_cond_arm, p_start, p_slow} = '0;
    {cfg_enable, cfg_strobe_in_en, cfg_strobe_out_en} = 3'h7;
    cfg_cond_mode = COND_NONE;
    {cfg_cond_value, narrower_owns, cfg_block_div_value} = '0;
    {cfg_clock_sel, cfg_block_external, cfg_block_div_load} = '0;
    {cpu_write_data, cpu_time_value, p_word} = '0;
    tick(20);
    check(pin_pulldown, 1'b1, "pull-down in reset");
    check(pin_oe, '0, "released in reset");
    check(counter_value, '0, "counter reset");
    reset_n = 1'b1;
    tick();
    check(pin_pulldown, 1'b0, "pull-down after reset");
    clk_test(3'h0, 10, 10, 1'b0);
    for (int n = 0; n < 6; n++) begin
      rnd();
      w = rng;
      rnd();
      send(w, rng[0], n == 2 ? rng[15:8] : '0, n == 4, n == 1);
    end
    link_enable = 1'b0;
    narrower_owns = '0;
    for (int n = 0; n < 4; n++) begin
      rnd();
      recv(rng, n[0]);
    end
    rnd();
    w = {rng[31:8], pin_in ^ 8'h5A};
    cfg_cond_mode = COND_EQ;
    cfg_cond_value = w[7:0];
    cpu_cond_arm = 1'b1;
    e0 = events;
    tick();
    cpu_cond_arm = 1'b0;
    recv(w, 1'b0);
    check(events - e0, 1, "condition event");
    rnd();
    w = rng;
    cfg_cond_mode = COND_NE;
    cfg_cond_value = ~w[7:0];
    cpu_cond_arm = 1'b1;
    e0 = events;
    tick();
    cpu_cond_arm = 1'b0;
    recv(w, 1'b1);
    check(events - e0, 1, "unequal condition event");
    cfg_cond_mode = COND_NONE;
    clk_test(3'h3, 10, 10, 1'b0);
    cfg_block_div_value = 8'h03;
    cfg_block_div_load = 6'h02;
    tick();
    cfg_block_div_value = 8'h02;
    cfg_block_external = 6'h04;
    cfg_block_div_load = 6'h04;
    tick();
    cfg_block_div_load = 6'h00;
    clk_test(3'h1, 30, 10, 1'b0);
    clk_test(3'h2, 40, 5, 1'b1);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
